// ===== rtl/adc_iq_capture_cdc.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1: Fifteen transceiver inputs: clock, select, data
// RL2: Pair each I with the following Q
// RL3: Sign-extend twelve-bit two's complement samples
// RL4: Crossing FIFO of 4096 24-bit entries
// RL5: Write pairs on select; read when consumer ready
// RL6: Full FIFO drops sample, sets sticky loss flag
// RL7: Any write to the loss register clears loss flag unless a drop lands that cycle; reset clears
// RL8: Messages framed by start and end markers
// RL9: Message length defaults to 8192, readable
// RL10: Sample clock source chosen by priority
// RL11: Drive transceiver clock when parameter set
// RL12: Output word holds 16-bit I and Q
// RL13: Honour backpressure, report losses
// RL14: Two sample-domain registers before FIFO
// RL15: Stream and registers run on control clock
// RL16: FIFO entry holds I upper, Q lower
// RL17: Reset empties FIFO, restarts message count
module adc_iq_capture_cdc
    import adc_capture_pkg::*;
#(
    parameter bit DRIVE_CLK   = 1'b1,
    parameter bit USE_CLK_OUT = 1'b1,
    parameter bit USE_CLK_IN  = 1'b0,
    parameter bit USE_CTL_CLK = 1'b1
)(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             wb_cyc,
    input  wire logic             wb_stb,
    input  wire logic             wb_we,
    input  wire logic [7:0]       wb_adr,
    input  wire logic [3:0]       wb_sel,
    input  wire logic [31:0]      wb_dat_w,
    output logic      [31:0]      wb_dat_r,
    output logic                  wb_ack,
    output logic                  irq,
    input  wire logic             rx_clk_out,
    input  wire logic             rx_clk_in,
    input  wire logic             iq_phase_select,
    input  wire logic [ADC_W-1:0] rx_data,
    output logic                  rx_clk,
    output logic [OUT_W-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic                  message_start_marker,
    output logic                  message_end_marker
);

    logic [SYNC_W-1:0] pin_stable;
    logic              sel_link_clk;
    logic              link_prev_reg;
    logic              sample_tick;
    logic              cap_vld_reg;
    logic              cap_sel_reg;
    logic [ADC_W-1:0]  cap_data_reg;
    pair_state_t       state_reg;
    logic [ADC_W-1:0]  i_hold_reg;
    logic              pair_vld_reg;
    logic [FIFO_W-1:0] pair_reg;
    logic              fifo_wr_ready;
    logic              fifo_rd_valid;
    logic [FIFO_W-1:0] fifo_rd_data;
    logic [FIFO_AW:0]  fifo_level;
    logic              load;
    logic              loss_evt;
    logic              msg_evt;
    logic [BEAT_W-1:0] beat_cnt_reg;
    logic [BEAT_W-1:0] len_beats;
    logic [BEAT_W-1:0] last_beat;
    logic              out_valid_reg;
    logic [OUT_W-1:0]  out_data_reg;
    logic              start_reg;
    logic              end_reg;
    logic [31:0]       msg_len_reg;
    logic              loss_flag_reg;
    logic [IRQ_W-1:0]  status_reg;
    logic [IRQ_W-1:0]  mask_reg;
    logic              ack_reg;
    logic [31:0]       dat_r_reg;
    logic              access;
    logic              bus_wr;
    logic [2:0]        div_cnt_reg;
    logic              rx_clk_reg;

    ////////////////////////////////////////////////////////////////
    // Pin capture: all fifteen transceiver inputs cross via three stages
    pin_sync u_sync (
        .clk    (clk),
        .nrst   (nrst),
        .pins   ({rx_clk_out, rx_clk_in, iq_phase_select, rx_data}), // RL1
        .stable (pin_stable)
    );

    // Clock source priority; control clock makes every cycle a sample
    assign sel_link_clk = USE_CLK_OUT ? pin_stable[PIN_CLK_OUT]
                                      : pin_stable[PIN_CLK_IN]; // RL10
    always_comb begin
        if (USE_CLK_OUT || USE_CLK_IN) begin
            sample_tick = sel_link_clk && !link_prev_reg; // RL10
        end else begin
            sample_tick = USE_CTL_CLK; // RL10
        end
    end

    // Edge finder for the selected link clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            link_prev_reg <= 1'b0;
        end else begin
            link_prev_reg <= sel_link_clk;
        end
    end

    // First sample register: pins taken at the link clock rising edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cap_vld_reg  <= 1'b0;
            cap_sel_reg  <= 1'b0;
            cap_data_reg <= '0;
        end else begin
            cap_vld_reg <= sample_tick; // RL14
            if (sample_tick) begin
                cap_sel_reg  <= pin_stable[PIN_IQ_SEL];
                cap_data_reg <= pin_stable[ADC_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Second register: de-interleave; a Q with no I before it is dropped
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg    <= PAIR_WAIT_I;
            i_hold_reg   <= '0;
            pair_vld_reg <= 1'b0;
            pair_reg     <= '0;
        end else begin
            pair_vld_reg <= 1'b0;
            if (cap_vld_reg) begin
                if (cap_sel_reg) begin
                    // Select marks I; a repeated I replaces the held one
                    i_hold_reg <= cap_data_reg; // RL2
                    state_reg  <= PAIR_WAIT_Q;
                end else begin
                    case (state_reg)
                        PAIR_WAIT_Q: begin
                            pair_reg     <= {i_hold_reg, cap_data_reg}; // RL16
                            pair_vld_reg <= 1'b1; // RL2 RL5 RL14
                            state_reg    <= PAIR_WAIT_I;
                        end
                        PAIR_WAIT_I: begin
                            state_reg <= PAIR_WAIT_I;
                        end
                        default: begin
                            state_reg <= PAIR_WAIT_I;
                        end
                    endcase
                end
            end
        end
    end

    // The transceiver never pauses, so a full FIFO costs a sample
    assign loss_evt = pair_vld_reg && !fifo_wr_ready; // RL6 RL13

    sample_fifo u_fifo (
        .clk      (clk),
        .nrst     (nrst), // RL17
        .wr_valid (pair_vld_reg), // RL4 RL5
        .wr_ready (fifo_wr_ready),
        .wr_data  (pair_reg),
        .rd_valid (fifo_rd_valid),
        .rd_ready (load), // RL5
        .rd_data  (fifo_rd_data),
        .level    (fifo_level)
    );

    ////////////////////////////////////////////////////////////////
    // Output stage; a length below one sample frames single samples
    assign len_beats = msg_len_reg[31:BYTES_LOG2]; // RL8
    assign last_beat = (len_beats == '0) ? '0 : len_beats - 1'b1;
    assign load      = fifo_rd_valid && (!out_valid_reg || out_ready); // RL13
    assign msg_evt   = out_valid_reg && out_ready && end_reg;

    // Word held until taken; beat count restarts after reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
            start_reg     <= 1'b0;
            end_reg       <= 1'b0;
            beat_cnt_reg  <= '0; // RL17
        end else if (load) begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= {{(HALF_W-ADC_W){fifo_rd_data[FIFO_W-1]}},
                              fifo_rd_data[FIFO_W-1:ADC_W],
                              {(HALF_W-ADC_W){fifo_rd_data[ADC_W-1]}},
                              fifo_rd_data[ADC_W-1:0]}; // RL3 RL12
            start_reg     <= beat_cnt_reg == '0; // RL8
            end_reg       <= beat_cnt_reg >= last_beat; // RL8
            if (beat_cnt_reg >= last_beat) begin
                beat_cnt_reg <= '0;
            end else begin
                beat_cnt_reg <= beat_cnt_reg + 1'b1;
            end
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    assign out_valid            = out_valid_reg;
    assign out_data             = out_data_reg;
    assign message_start_marker = out_valid_reg && start_reg;
    assign message_end_marker   = out_valid_reg && end_reg;

    ////////////////////////////////////////////////////////////////
    // Bus slave: one-cycle ack, write lands on the acknowledged edge
    assign access = wb_cyc && wb_stb && !ack_reg; // RL15
    assign bus_wr = wb_cyc && wb_stb && wb_we && ack_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access;
        end
    end

    // Read data latched at the request; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dat_r_reg <= '0;
        end else if (access) begin
            case (wb_adr)
                REG_MSG_LEN:    dat_r_reg <= msg_len_reg; // RL9
                REG_LOSS:       dat_r_reg <= 32'(loss_flag_reg);
                REG_IRQ_STATUS: dat_r_reg <= 32'(status_reg);
                REG_IRQ_MASK:   dat_r_reg <= 32'(mask_reg);
                REG_LEVEL:      dat_r_reg <= 32'(fifo_level);
                default:        dat_r_reg <= '0;
            endcase
        end
    end

    assign wb_ack   = ack_reg;
    assign wb_dat_r = dat_r_reg;

    // Length register honours byte lanes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            msg_len_reg <= MSG_LEN_RESET; // RL9
        end else if (bus_wr && wb_adr == REG_MSG_LEN) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel[b]) begin
                    msg_len_reg[8*b +: 8] <= wb_dat_w[8*b +: 8];
                end
            end
        end
    end

    // Loss flag: set beats a same-cycle clear so no drop goes unseen
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loss_flag_reg <= 1'b0; // RL7
        end else if (loss_evt) begin
            loss_flag_reg <= 1'b1; // RL6
        end else if (bus_wr && wb_adr == REG_LOSS) begin
            loss_flag_reg <= 1'b0; // RL7
        end
    end

    // Interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_reg <= '0;
            mask_reg   <= '0;
        end else begin
            if (bus_wr && wb_adr == REG_IRQ_STATUS && wb_sel[0]) begin
                status_reg <= (status_reg & ~wb_dat_w[IRQ_W-1:0])
                            | {msg_evt, loss_evt};
            end else begin
                status_reg <= status_reg | {msg_evt, loss_evt};
            end
            if (bus_wr && wb_adr == REG_IRQ_MASK && wb_sel[0]) begin
                mask_reg <= wb_dat_w[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////
    // Transceiver clock divider; held low when supplied elsewhere
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_cnt_reg <= '0;
            rx_clk_reg  <= 1'b0;
        end else if (div_cnt_reg == RX_DIV_LAST) begin
            div_cnt_reg <= '0;
            rx_clk_reg  <= !rx_clk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    assign rx_clk = DRIVE_CLK && rx_clk_reg; // RL11

    ////////////////////////////////////////////////////////////////
    // Checks on the control clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_loss_sets: // RL6
    assert property (pair_vld_reg && !fifo_wr_ready |=> loss_flag_reg)
        else $error("drop did not set loss flag");

    a_loss_sticky: // RL6
    assert property (loss_flag_reg && !(bus_wr && wb_adr == REG_LOSS)
                     |=> loss_flag_reg)
        else $error("loss flag fell without a write");

    a_loss_clears: // RL7
    assert property (bus_wr && wb_adr == REG_LOSS && !loss_evt
                     |=> !loss_flag_reg)
        else $error("write did not clear loss flag");

    a_pair_forms: // RL2 RL16
    assert property (cap_vld_reg && !cap_sel_reg && state_reg == PAIR_WAIT_Q
                     |=> pair_vld_reg
                         && pair_reg == {$past(i_hold_reg), $past(cap_data_reg)})
        else $error("I/Q pair not formed");

    a_sign_extend: // RL3
    assert property (out_valid |-> out_data[31:27] == {5{out_data[27]}}
                     && out_data[15:11] == {5{out_data[11]}})
        else $error("sample field not sign extended");

    a_out_holds: // RL13
    assert property (out_valid && !out_ready
                     |=> out_valid && $stable(out_data))
        else $error("output changed under backpressure");

    // A word loaded on the same edge must open the next message
    a_msg_restart: // RL8
    assert property (message_end_marker && out_ready
                     |=> message_start_marker || (!out_valid && beat_cnt_reg == '0))
        else $error("message count did not restart");

    a_fifo_push: // RL5
    assert property (pair_vld_reg && fifo_wr_ready && !load
                     |=> fifo_level == $past(fifo_level) + 1'b1)
        else $error("pair not written to FIFO");

    a_len_default: // RL9
    assert property ($rose(nrst) |-> msg_len_reg == MSG_LEN_RESET)
        else $error("length not at default after reset");

endmodule

`default_nettype wire

// ===== pkg/adc_capture_pkg.sv
package adc_capture_pkg;

    // Sample and word widths
    localparam int ADC_W      = 12;
    localparam int HALF_W     = 16;
    localparam int OUT_W      = 32;
    localparam int FIFO_W     = 24;
    localparam int FIFO_DEPTH = 4096;
    localparam int FIFO_AW    = 12;
    localparam logic [FIFO_AW:0] FIFO_FULL = 13'h1000;

    // Synchronised pin bundle layout, data in the low bits
    localparam int SYNC_W      = 15;
    localparam int PIN_CLK_OUT = 14;
    localparam int PIN_CLK_IN  = 13;
    localparam int PIN_IQ_SEL  = 12;

    // Message framing: four bytes per complex sample
    localparam int BYTES_LOG2 = 2;
    localparam int BEAT_W     = 30;

    // Register byte offsets
    localparam logic [7:0] REG_MSG_LEN    = 8'h00;
    localparam logic [7:0] REG_LOSS       = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
    localparam logic [7:0] REG_LEVEL      = 8'h10;
    localparam logic [31:0] MSG_LEN_RESET = 32'h0000_2000;

    // Interrupt status bits
    localparam int IRQ_W    = 2;
    localparam int IRQ_LOSS = 0;
    localparam int IRQ_MSG  = 1;

    // Transceiver clock produced from the 40 MHz control clock
    localparam int CLK_PERIOD_NS   = 25;
    localparam int LINK_PERIOD_NS  = 200;
    localparam int RX_CLK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [2:0] RX_DIV_LAST = 3'(RX_CLK_HALF_CYC - 1);

    typedef enum logic {
        PAIR_WAIT_I = 1'b0,
        PAIR_WAIT_Q = 1'b1
    } pair_state_t;

endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync
    import adc_capture_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [SYNC_W-1:0] pins,
    output logic      [SYNC_W-1:0] stable
);

    ////////////////////////////////////////////////////////////////
    // Three stages per pin; a change counts once stages two and three agree
    for (genvar g = 0; g < SYNC_W; g++) begin : g_bit
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic q_reg;
        always_ff @(posedge clk) begin
            if (!nrst) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
                q_reg  <= 1'b0;
            end else begin
                s1_reg <= pins[g];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                if (s2_reg == s3_reg) begin
                    q_reg <= s3_reg;
                end
            end
        end
        assign stable[g] = q_reg;
    end

endmodule

`default_nettype wire

// ===== rtl/sample_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module sample_fifo
    import adc_capture_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               wr_valid,
    output logic                    wr_ready,
    input  wire logic [FIFO_W-1:0]  wr_data,
    output logic                    rd_valid,
    input  wire logic               rd_ready,
    output logic      [FIFO_W-1:0]  rd_data,
    output logic      [FIFO_AW:0]   level
);

    logic [FIFO_W-1:0]  mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr_reg;
    logic [FIFO_AW-1:0] rd_ptr_reg;
    logic [FIFO_AW:0]   count_reg;
    logic               push;
    logic               pop;

    // Honest full and empty from the occupancy count
    assign wr_ready = count_reg != FIFO_FULL;
    assign rd_valid = count_reg != '0;
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;
    assign rd_data  = mem[rd_ptr_reg];
    assign level    = count_reg;

    ////////////////////////////////////////////////////////////////
    // Storage carries no reset; only pointers define content
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_data;
        end
    end

    // Pointers wrap naturally at the power-of-two depth
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== test/xcvr_rx_model.sv
`timescale 1ns/10ps
`default_nettype none

// Transceiver receive port: a new pair starts only while run is high; a started pair finishes
module xcvr_rx_model (
    input  wire logic        run,
    input  wire logic [11:0] i_next,
    input  wire logic [11:0] q_next,
    output logic             lclk,
    output logic             iq_sel,
    output logic      [11:0] data,
    output logic             sent_tgl,
    output logic      [11:0] sent_i,
    output logic      [11:0] sent_q
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pins change only while the clock is low, so they stand still around each rise
    initial begin
        lclk = 1'b0;
        iq_sel = 1'b0;
        data = 12'h000;
        sent_tgl = 1'b0;
        sent_i = 12'h000;
        sent_q = 12'h000;
        #3;
        forever begin
            if (run !== 1'b1) begin
                #25;
            end else begin
                sent_i = i_next;
                sent_q = q_next;
                sent_tgl = ~sent_tgl;
                iq_sel = 1'b1;
                data = sent_i;
                #100 lclk = 1'b1;
                #100 lclk = 1'b0;
                iq_sel = 1'b0;
                data = sent_q;
                #100 lclk = 1'b1;
                #100 lclk = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/adc_iq_capture_cdc_tb.sv
`timescale 1ns/10ps
`default_nettype none

module adc_iq_capture_cdc_tb;
    import adc_capture_pkg::*;
    logic             clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, irq, rx_clk, prev;
    logic [7:0]       wb_adr;
    logic [3:0]       wb_sel;
    logic [31:0]      wb_dat_w, wb_dat_r, out_data, seed, sq[$], rq[$];
    logic             out_valid, out_ready, msg_start, msg_end, lclk, iq_sel;
    logic             sent_tgl, tgl_seen, run, skip, stall;
    logic [ADC_W-1:0] rx_data, i_next, q_next, sent_i, sent_q;
    int               n_mismatch, checked, n_pairs, cnt, words, e;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and far side
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    adc_iq_capture_cdc #(.DRIVE_CLK(1'b1), .USE_CLK_OUT(1'b1), .USE_CLK_IN(1'b0),
                         .USE_CTL_CLK(1'b1)) i_dut (
        .clk(clk), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .irq(irq), .rx_clk_out(lclk), .rx_clk_in(rx_clk),
        .iq_phase_select(iq_sel), .rx_data(rx_data), .rx_clk(rx_clk),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
        .message_start_marker(msg_start), .message_end_marker(msg_end));

    xcvr_rx_model i_xcvr (.run(run), .i_next(i_next), .q_next(q_next), .lclk(lclk),
        .iq_sel(iq_sel), .data(rx_data), .sent_tgl(sent_tgl), .sent_i(sent_i),
        .sent_q(sent_q));

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic [31:0] word(input logic [11:0] i, input logic [11:0] q);
        return {{4{i[11]}}, i, {4{q[11]}}, q};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int k;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat_w <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 100);
        if (k >= 100) chk(32'h0, 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        wb(1'b0, a, 4'hf, 32'h0);
    endtask

    task automatic chk_irq(input logic exp);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask

    // Waiting on model progress; the watchdog bounds it
    task automatic wait_pairs(input int n);
        int t;
        t = n_pairs + n;
        while (n_pairs < t) @(posedge clk);
    endtask

    // One pair lasts 16 cycles, so 20 lets the model finish its last pair
    task automatic drain();
        int k;
        run <= 1'b0;
        repeat (20) @(posedge clk);
        for (k = 0; k < 3000 && sq.size() != 0; k++) @(posedge clk);
        chk(sq.size(), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Random backpressure and sample values; expectations noted as pairs leave
    always @(posedge clk) begin
        seed = xs(seed);
        out_ready <= !stall && (seed[1:0] != 2'b00);
        if (sent_tgl !== tgl_seen) begin
            tgl_seen = sent_tgl;
            n_pairs++;
            if (!skip) sq.push_back(word(sent_i, sent_q));
            i_next <= (n_pairs % 8 == 1) ? 12'h800 : seed[27:16];
            q_next <= (n_pairs % 8 == 1) ? 12'h7ff : seed[13:2];
        end
    end

    // Oldest note compared as each result appears
    always @(posedge clk) begin
        if (nrst && wb_ack && !wb_we && rq.size() != 0) chk(wb_dat_r, rq.pop_front());
        if (nrst && out_valid && out_ready) begin
            if (!skip) chk(out_data, (sq.size() != 0) ? sq.pop_front() : 32'hdead_beef);
            chk({30'h0, msg_start, msg_end}, {30'h0, cnt == 0, cnt == words - 1});
            cnt = (cnt == words - 1) ? 0 : cnt + 1;
        end
    end

    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
        out_ready = 1'b0;
        {run, skip, stall, tgl_seen} = 4'h0;
        i_next = 12'h800;
        q_next = 12'h7ff;
        seed = 32'h0000_8903;
        {n_mismatch, checked, n_pairs, cnt} = 128'h0;
        words = 2048;
        do_reset();
        rd(REG_MSG_LEN, MSG_LEN_RESET);
        rd(REG_LOSS, 32'h0);
        rd(REG_LEVEL, 32'h0);
        rd(REG_IRQ_STATUS, 32'h0);
        rd(8'h20, 32'h0);
        wb(1'b1, 8'h20, 4'hf, 32'hffff_ffff);
        wb(1'b1, REG_MSG_LEN, 4'hf, 32'h0000_0010);
        wb(1'b1, REG_MSG_LEN, 4'h1, 32'haabb_cc0c);
        rd(REG_MSG_LEN, 32'h0000_000c);
        words = 3;
        e = 0;
        // Settle past the edge so an edge launched there is not counted twice
        #1;
        prev = rx_clk;
        repeat (80) begin
            @(posedge clk);
            #1;
            if (rx_clk && !prev) e++;
            prev = rx_clk;
        end
        chk(e, 32'd10);
        // Streaming with random stalls, boundary values every eighth pair
        run <= 1'b1;
        wait_pairs(40);
        drain();
        rd(REG_IRQ_STATUS, 32'h0000_0002);
        wb(1'b1, REG_IRQ_MASK, 4'h1, 32'h2);
        chk_irq(1'b1);
        wb(1'b1, REG_IRQ_STATUS, 4'h1, 32'h2);
        chk_irq(1'b0);
        wb(1'b1, REG_IRQ_MASK, 4'h1, 32'h1);
        // Consumer stalls while samples keep coming: FIFO fills, then drops
        skip = 1'b1;
        stall = 1'b1;
        run <= 1'b1;
        wait_pairs(4110);
        run <= 1'b0;
        repeat (20) @(posedge clk);
        rd(REG_LEVEL, 32'(FIFO_FULL));
        rd(REG_LOSS, 32'h1);
        rd(REG_IRQ_STATUS, 32'h1);
        chk_irq(1'b1);
        wb(1'b1, REG_LOSS, 4'h0, 32'h0);
        rd(REG_LOSS, 32'h0);
        wb(1'b1, REG_IRQ_STATUS, 4'h1, 32'h1);
        chk_irq(1'b0);
        // Reset with a full FIFO, then a fresh message
        do_reset();
        chk({31'h0, out_valid}, 32'h0);
        rd(REG_LEVEL, 32'h0);
        rd(REG_MSG_LEN, MSG_LEN_RESET);
        sq.delete();
        cnt = 0;
        skip = 1'b0;
        stall = 1'b0;
        words = 2;
        wb(1'b1, REG_MSG_LEN, 4'hf, 32'h0000_0008);
        run <= 1'b1;
        wait_pairs(10);
        drain();
        close_out();
    end
endmodule
`default_nettype wire
